// file: verilog/eeprom_slave.sv
// two-wire byte memory slave: bus engine, array, id page and byte check bits
// ***************************************************************************
// ***************************************************************************
`timescale 1ns/1ps
module eeprom_slave (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] chip_select_straps,
    input wire logic write_protect_input,
    output logic prog_busy,
    output logic ecc_fixed
);
    typedef enum logic [2:0] {
        PH_IDLE, PH_SELECT, PH_ADDR_HI, PH_ADDR_LO, PH_WRITE, PH_READ
    } phase_t;

    // single-bit correcting parity over a byte: four hamming bits plus overall
    function automatic logic [eeprom_pkg::ECC_W-1:0] ecc_gen(input logic [7:0] d);
        logic [3:0] h;
        h[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        h[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        h[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        h[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        ecc_gen = {^{d, h}, h};
    endfunction

    // ***********************************************************************
    // storage
    // ***********************************************************************
    logic [7:0] mem_q [eeprom_pkg::ARRAY_BYTES];
    logic [eeprom_pkg::ECC_W-1:0] mem_ecc_q [eeprom_pkg::ARRAY_BYTES];
    logic [7:0] id_q [eeprom_pkg::PAGE_BYTES];
    logic id_locked_q;

    // ***********************************************************************
    // bus edge and condition detection
    // ***********************************************************************
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;

    // previous line levels, for edge detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // ***********************************************************************
    // byte engine
    // ***********************************************************************
    phase_t phase_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic is_id_q, ack_q, wrote_q, lock_req_q;
    logic [eeprom_pkg::ADDR_W-1:0] addr_q;
    logic [7:0] rx_byte;
    logic sel_match;
    logic wr_allowed;
    logic [7:0] rd_byte;
    logic [7:0] rd_raw;
    logic [eeprom_pkg::ECC_W-1:0] syn;
    logic [eeprom_pkg::ECC_W-1:0] ecc_calc;
    logic [7:0] fix_mask;

    assign rx_byte = {shift_q[6:0], sda_in};
    // straps arrive already resolved; a floating pin is pulled to zero outside
    // judged in the ack slot, so the whole received byte sits in the shifter
    assign sel_match = (shift_q[7:4] == eeprom_pkg::TYPE_ARRAY
                        || shift_q[7:4] == eeprom_pkg::TYPE_IDPAGE)
                       && shift_q[3:1] == chip_select_straps;
    // protect blocks array data; id page obeys its own lock
    assign wr_allowed = is_id_q ? ~id_locked_q : ~write_protect_input;

    // read path with single-bit correction of stored array data
    assign rd_raw = mem_q[addr_q];
    // overall check must cover every stored bit, else weight-three syndromes go unflagged
    assign ecc_calc = ecc_gen(rd_raw);
    assign syn = ecc_calc ^ mem_ecc_q[addr_q]
                 ^ {^(ecc_calc[3:0] ^ mem_ecc_q[addr_q][3:0]), 4'h0};
    always_comb begin
        fix_mask = 8'h00;
        if (syn[4]) begin
            unique case (syn[3:0])
                4'h3: fix_mask = 8'h01;
                4'h5: fix_mask = 8'h02;
                4'h6: fix_mask = 8'h04;
                4'h7: fix_mask = 8'h08;
                4'h9: fix_mask = 8'h10;
                4'ha: fix_mask = 8'h20;
                4'hb: fix_mask = 8'h40;
                4'hc: fix_mask = 8'h80;
                default: fix_mask = 8'h00;
            endcase
        end
    end
    assign rd_byte = is_id_q ? (lock_req_q ? {7'h00, id_locked_q}
                                           : id_q[addr_q[eeprom_pkg::ID_ADDR_W-1:0]])
                             : (rd_raw ^ fix_mask);

    // protocol sequencing, sampled on serial clock rising edges
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= PH_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            is_id_q <= 1'b0;
            ack_q <= 1'b0;
            addr_q <= '0;
            lock_req_q <= 1'b0;
        end else if (start_cond) begin
            phase_q <= PH_SELECT;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
        end else if (stop_cond || prog_busy) begin
            // no response while programming: drops to idle, though a start in the same cycle still wins
            phase_q <= PH_IDLE;
            ack_q <= 1'b0;
        end else if (phase_q != PH_IDLE && scl_rise) begin
            if (bit_q == eeprom_pkg::BIT_ACK) begin
                bit_q <= 4'h0;
                // master nack ends a read
                if (phase_q == PH_READ && sda_in) begin
                    phase_q <= PH_IDLE;
                end
            end else begin
                shift_q <= rx_byte;
                bit_q <= bit_q + 4'h1;
            end
        end else if (phase_q != PH_IDLE && scl_fall) begin
            ack_q <= 1'b0;
            if (bit_q == eeprom_pkg::BIT_ACK) begin
                unique case (phase_q)
                    PH_SELECT: begin
                        if (sel_match) begin
                            ack_q <= 1'b1;
                            is_id_q <= shift_q[4];
                            phase_q <= shift_q[0] ? PH_READ : PH_ADDR_HI;
                        end else begin
                            phase_q <= PH_IDLE; // deselect into standby
                        end
                    end
                    PH_ADDR_HI: begin
                        ack_q <= 1'b1; // addresses acked even when protected
                        addr_q[12:8] <= shift_q[4:0];
                        lock_req_q <= shift_q[eeprom_pkg::LOCK_ADDR_BIT - 8];
                        phase_q <= PH_ADDR_LO;
                    end
                    PH_ADDR_LO: begin
                        ack_q <= 1'b1;
                        addr_q[7:0] <= shift_q;
                        phase_q <= PH_WRITE;
                    end
                    PH_WRITE: begin
                        ack_q <= wr_allowed; // data bytes nacked when blocked
                        // rollover stays inside the 32-byte page
                        addr_q[4:0] <= addr_q[4:0] + 5'h01;
                    end
                    PH_READ: begin
                        ack_q <= 1'b0;
                    end
                    default: phase_q <= PH_IDLE;
                endcase
            end else if (bit_q == 4'h0 && phase_q == PH_READ) begin
                // sequential read wraps over the whole array
                addr_q <= addr_q + 13'h0001;
            end
        end
    end

    // ***********************************************************************
    // write buffering and programming cycle
    // ***********************************************************************
    logic [7:0] page_buf_q [eeprom_pkg::PAGE_BYTES];
    logic [eeprom_pkg::PAGE_BYTES-1:0] page_dirty_q;
    logic [eeprom_pkg::ADDR_W-1:0] page_base_q;
    logic page_id_q, page_lock_q;
    logic data_taken;
    assign data_taken = scl_fall && phase_q == PH_WRITE && bit_q == eeprom_pkg::BIT_ACK
                        && wr_allowed;

    // latch bytes until stop, then commit in one programming step
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_dirty_q <= '0;
            page_base_q <= '0;
            page_id_q <= 1'b0;
            page_lock_q <= 1'b0;
            wrote_q <= 1'b0;
            prog_busy <= 1'b0;
            id_locked_q <= 1'b0;
            for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
                page_buf_q[i] <= 8'h00;
            end
        end else if (start_cond) begin
            wrote_q <= 1'b0;
            page_dirty_q <= '0;
        end else if (data_taken) begin
            wrote_q <= 1'b1;
            page_base_q <= addr_q;
            page_id_q <= is_id_q;
            page_lock_q <= lock_req_q;
            page_buf_q[addr_q[4:0]] <= shift_q;
            page_dirty_q[addr_q[4:0]] <= 1'b1;
        end else if (stop_cond && wrote_q) begin
            prog_busy <= 1'b1;
            wrote_q <= 1'b0;
        end else if (prog_busy) begin
            prog_busy <= 1'b0;
            page_dirty_q <= '0;
            if (page_id_q && page_lock_q) begin
                id_locked_q <= 1'b1; // permanent until power loss
            end
        end
    end

    // commit dirty bytes of the held page unless it carries the lock; array bytes get fresh check bits
    always_ff @(posedge clk_sys) begin
        if (prog_busy && !page_lock_q) begin
            for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
                if (page_dirty_q[i]) begin
                    if (page_id_q) begin
                        id_q[i] <= page_buf_q[i];
                    end else begin
                        mem_q[{page_base_q[12:5], 5'(i)}] <= page_buf_q[i];
                        mem_ecc_q[{page_base_q[12:5], 5'(i)}] <= ecc_gen(page_buf_q[i]);
                    end
                end
            end
        end
    end

    // ***********************************************************************
    // transmit path and open-drain pin
    // ***********************************************************************
    // load next byte on the falling edge that opens a read byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= 8'hff;
            ecc_fixed <= 1'b0;
        end else if (scl_fall && phase_q == PH_READ && bit_q == 4'h0) begin
            tx_q <= rd_byte;
            ecc_fixed <= |fix_mask & ~is_id_q;
        end else if (scl_fall && phase_q == PH_READ && bit_q < eeprom_pkg::BIT_ACK) begin
            tx_q <= {tx_q[6:0], 1'b1}; // bits change only while clock is low
        end
    end

    // output value is always low; only the enable moves
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            sda_out <= 1'b0;
            if (bit_q == eeprom_pkg::BIT_ACK && phase_q != PH_READ) begin
                sda_oe <= (phase_q != PH_IDLE) && (phase_q == PH_SELECT ? sel_match
                          : phase_q == PH_WRITE ? wr_allowed : 1'b1);
            end else if (phase_q == PH_READ && bit_q < eeprom_pkg::BIT_ACK) begin
                sda_oe <= (bit_q == 4'h0) ? ~rd_byte[7] : ~tx_q[6];
            end else begin
                sda_oe <= 1'b0; // release for master ack of read data
            end
        end
    end

    // ***********************************************************************
    // checks
    // ***********************************************************************
    // one commit cycle, then quiet again
    sequence s_commit_pulse;
        prog_busy ##1 !prog_busy;
    endsequence

    a_open_drain_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sda_out == 1'b0) else $error("data pin drives a high level");

    a_strap_mismatch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scl_fall && phase_q == PH_SELECT && bit_q == eeprom_pkg::BIT_ACK
        && shift_q[3:1] != chip_select_straps |=> !sda_oe && !ack_q)
        else $error("select acked with wrong straps");

    a_protect_nack: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scl_fall && phase_q == PH_WRITE && bit_q == eeprom_pkg::BIT_ACK && !is_id_q
        && write_protect_input |=> !sda_oe) else $error("protected data acked");

    a_addr_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scl_fall && phase_q == PH_ADDR_HI && bit_q == eeprom_pkg::BIT_ACK && !prog_busy
        && !start_cond && !stop_cond |=> sda_oe) else $error("address byte not acked");

    a_stop_programs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stop_cond && wrote_q && !start_cond |=> s_commit_pulse)
        else $error("stop failed to launch programming");

    a_type_filter: assert property (@(posedge clk_sys) disable iff (!rst_n)
        scl_fall && phase_q == PH_SELECT && bit_q == eeprom_pkg::BIT_ACK
        && shift_q[7:5] != 3'h5 |=> !sda_oe) else $error("bad type code acked");
endmodule

// file: verilog/eeprom_pkg.sv
// shared constants for the serial byte-memory slave front end
package eeprom_pkg;
    localparam int unsigned ARRAY_BYTES = 8192;
    localparam int unsigned PAGE_BYTES = 32;
    localparam int unsigned PAGE_COUNT = 256;
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned ID_ADDR_W = 5;
    localparam logic [3:0] TYPE_ARRAY = 4'ha;
    localparam logic [3:0] TYPE_IDPAGE = 4'hb;
    localparam int unsigned LOCK_ADDR_BIT = 10; // msb-byte bit 2 selects the lock command
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int unsigned ECC_W = 5;
    localparam int unsigned MAX_SCL_KHZ = 1000;
endpackage

// file: testbench/i2c_master_model.sv
// two-wire bus master model driving the serial clock and the data line
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl_q,
    output logic sda_low_q
);
    // ****************************************
    // bus timing
    // ****************************************
    // 126 clocks per bit keeps the serial clock just under 1 MHz
    localparam int HALF = 63;

    // clock driven high and data released while idle; the pull-up holds data high
    initial begin
        scl_q = 1'b1;
        sda_low_q = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // data moves only while the clock is low, sampled mid high phase
    task automatic clock_bit(input logic b, output logic r);
        wait_clk(16);
        sda_low_q <= ~b;
        wait_clk(HALF - 16);
        scl_q <= 1'b1;
        wait_clk(HALF / 2);
        r = sda_line;
        wait_clk(HALF - HALF / 2);
        scl_q <= 1'b0;
    endtask

    // ****************************************
    // bus conditions and bytes
    // ****************************************
    // also serves as repeated start after an acknowledge
    task automatic start_cond();
        wait_clk(16);
        sda_low_q <= 1'b0;
        wait_clk(HALF - 16);
        scl_q <= 1'b1;
        wait_clk(HALF / 2);
        sda_low_q <= 1'b1;
        wait_clk(HALF - HALF / 2);
        scl_q <= 1'b0;
    endtask

    // data rises while the clock stays high
    task automatic stop_cond();
        wait_clk(16);
        sda_low_q <= 1'b1;
        wait_clk(HALF - 16);
        scl_q <= 1'b1;
        wait_clk(HALF / 2);
        sda_low_q <= 1'b0;
        wait_clk(HALF - HALF / 2);
    endtask

    // msb first, line released on the ninth pulse for the acknowledge
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], r);
        end
        clock_bit(1'b1, r);
        ack = ~r;
    endtask

    // master pulls the ninth bit low to ask for more data
    task automatic recv_byte(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(~give_ack, r);
    endtask
endmodule

// file: testbench/tb.sv
// self-checking bench for the serial byte-memory slave
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] chip_select_straps = 3'h0;
    logic write_protect_input = 1'b0;
    logic scl_q, sda_low_q, sda_out, sda_oe, prog_busy, ecc_fixed, sda_line;
    int num_errors = 0;
    int tests_run = 0;
    int busy_cnt = 0;
    // {ack expected, straps, select byte}
    localparam logic [11:0] ROWS [9] = '{12'h8a0, 12'h0a2, 12'h8b0, 12'h090, 12'hfae,
        12'h7ac, 12'h5ae, 12'h0c0, 12'hdaa};

    // ****************************************
    // clock, wiring and instances
    // ****************************************
    always #4 clk_sys = ~clk_sys;
    // wired-and data line with pull-up
    assign sda_line = ~(sda_low_q | (sda_oe & ~sda_out));

    eeprom_slave i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_q), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
        .write_protect_input(write_protect_input), .prog_busy(prog_busy),
        .ecc_fixed(ecc_fixed));
    i2c_master_model i_master (.clk_sys(clk_sys), .sda_line(sda_line), .scl_q(scl_q),
        .sda_low_q(sda_low_q));

    // ****************************************
    // monitors and helpers
    // ****************************************
    // count commit pulses; the device may only ever pull the line low
    always @(posedge clk_sys) begin
        if (prog_busy === 1'b1) begin
            busy_cnt++;
        end
        if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, sda_out, 1'b0);
            num_errors++;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // select, two address bytes, one or two data bytes, stop
    task automatic wr(input logic [7:0] sel, input logic [15:0] addr, input logic [7:0] d0,
            input logic [7:0] d1, input int n, input logic dack);
        logic a;
        int b0;
        b0 = busy_cnt;
        i_master.start_cond();
        i_master.send_byte(sel, a);
        chk({7'h0, a}, 8'h01);
        i_master.send_byte(addr[15:8], a);
        chk({7'h0, a}, 8'h01);
        i_master.send_byte(addr[7:0], a);
        chk({7'h0, a}, 8'h01);
        i_master.send_byte(d0, a);
        chk({7'h0, a}, {7'h0, dack});
        if (n > 1) begin
            i_master.send_byte(d1, a);
            chk({7'h0, a}, {7'h0, dack});
        end
        i_master.stop_cond();
        // a refused write must not start a programming cycle
        chk(8'(busy_cnt - b0), {7'h0, dack});
    endtask

    // dummy write of the address, repeated start, one byte read and nacked
    task automatic rd(input logic [7:0] sel, input logic [15:0] addr, input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        i_master.start_cond();
        i_master.send_byte(sel, a);
        i_master.send_byte(addr[15:8], a);
        i_master.send_byte(addr[7:0], a);
        i_master.start_cond();
        i_master.send_byte(sel | 8'h01, a);
        chk({7'h0, a}, 8'h01);
        i_master.recv_byte(1'b0, d);
        i_master.stop_cond();
        chk(d, exp);
        chk({7'h0, ecc_fixed}, 8'h00);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic a;
        repeat (10) @(posedge clk_sys);
        chk({6'h0, sda_oe, prog_busy}, 8'h00);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // type codes and strap matching from the table
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            chip_select_straps <= ROWS[i][10:8];
            i_master.start_cond();
            i_master.send_byte(ROWS[i][7:0], a);
            i_master.stop_cond();
            chk({7'h0, a}, {7'h0, ROWS[i][11]});
        end
        @(posedge clk_sys);
        chip_select_straps <= 3'h0;
        // second byte wraps from the page end to its first byte
        wr(8'ha0, 16'h001f, 8'h5a, 8'h3c, 2, 1'b1);
        rd(8'ha0, 16'h001f, 8'h5a);
        rd(8'ha0, 16'h0000, 8'h3c);
        @(posedge clk_sys);
        write_protect_input <= 1'b1;
        wr(8'ha0, 16'h001f, 8'ha5, 8'h00, 1, 1'b0);
        rd(8'ha0, 16'h001f, 8'h5a);
        @(posedge clk_sys);
        write_protect_input <= 1'b0;
        wr(8'hb0, 16'h0000, 8'h77, 8'h00, 1, 1'b1);
        rd(8'hb0, 16'h0000, 8'h77);
        wr(8'hb0, 16'h0400, 8'h02, 8'h00, 1, 1'b1);
        wr(8'hb0, 16'h0000, 8'h11, 8'h00, 1, 1'b0);
        end_sim();
    end

    // watchdog sized well above the expected run of about 62000 cycles
    initial begin
        repeat (95000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end
endmodule
